// ---- rtl/mfd_regs.vh ----
/*
 Constants for the packet data path: clock ratios, FIFO geometry,
 receive status layout and PHY select decode.
 Assumes the including file is plain Verilog-2005.
*/
`ifndef MFD_REGS_VH
`define MFD_REGS_VH
// System clock rate in MHz
`define MFD_CLK_MHZ 250
// DMA engine rate in MHz
`define MFD_DMA_MHZ 50
// System cycles per DMA enable
`define MFD_DMA_DIV (`MFD_CLK_MHZ / `MFD_DMA_MHZ)
// Divider reset value
`define MFD_DIV_RST 3'h0
// FIFO address width and depth in 16-bit words
`define MFD_FIFO_AW 3
`define MFD_FIFO_DEPTH (1 << `MFD_FIFO_AW)
// Bad CRC position in the receive status word
`define MFD_BAD_CRC_BIT 13
// Bank that maps the PHY select
`define MFD_PHY_BANK 3'h7
// Highest host address that maps the PHY select
`define MFD_PHY_ADDR_TOP 4'h7
// Memory address width and address step per 32-bit cycle
`define MFD_ADDR_W 16
`define MFD_ADDR_STEP 16'h0004
// Last nibble index inside a 16-bit word
`define MFD_LAST_NIB 2'h3
`endif

// ---- rtl/mfd_datapath.v ----
/*
 Packet data path: nibble link, two 16-bit FIFOs, 32-bit DMA engine.
 Assumes one 250 MHz clock; PHY pins are synchronised here.
*/
// Functional notes
// RQ1 - Transmit nibbles driven on four outputs
// RQ2 - PHY supplies nibble-rate transmit clock
// RQ3 - Receive nibbles sampled on receive clock
// RQ4 - Code error discards frame, sets bit 13
// RQ5 - PHY select low: low eight addresses, bank 7
// RQ6 - Leading n means active low
// RQ7 - Host keeps bus clock within limits
// RQ8 - Transmit and receive logic fully independent
// RQ9 - Two 16-bit FIFOs, 32-bit DMA side
// RQ10 - DMA runs at 50 MHz, 32-bit path
// RQ11 - DMA fetches transmit, stores receive data
// RQ12 - Two receive words per memory cycle
// RQ13 - Separate transmit and receive counters
// RQ14 - Alternate transmit and receive when both pending
// RQ15 - Management clock, data out, data in
// RQ16 - Receive valid frames received nibbles
// RQ17 - Fast envelope covers 100 Mbps transmission
// RQ18 - Safe crossing from nibble clock domains
`timescale 1ns/1ps
`include "mfd_regs.vh"
module mfd_datapath (
   input  wire        clock,
   input  wire        rstn,
   input  wire        tx_nibble_clock,
   input  wire        rx_nibble_clock,
   input  wire [3:0]  rx_nibble,
   input  wire        rx_dv,
   input  wire        rx_err,
   input  wire        mgmt_data_in,
   input  wire        mgmt_clock_set,
   input  wire        mgmt_data_set,
   input  wire        host_access,
   input  wire [3:0]  host_addr,
   input  wire [2:0]  bank_sel,
   input  wire        speed_fast,
   input  wire        tx_go,
   input  wire [15:0] tx_base,
   input  wire [15:0] tx_dwords,
   input  wire [15:0] rx_base,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   output reg  [3:0]  tx_nibble,
   output reg         fast_tx_envelope,
   output reg         mgmt_clock_out,
   output reg         mgmt_data_out,
   output reg         mgmt_data_seen,
   output reg         phy_select_out_n,
   output reg         tx_busy,
   output reg         rx_done,
   output reg  [15:0] rx_status,
   output reg  [15:0] rx_byte_count,
   output reg         mem_req,
   output reg         mem_we,
   output reg  [15:0] mem_addr,
   output reg  [31:0] mem_wdata
);
   localparam AW = `MFD_FIFO_AW;
   localparam DEPTH = `MFD_FIFO_DEPTH;
   localparam ST_IDLE = 2'b00;  // DMA idle
   localparam ST_TXRD = 2'b01;  // DMA transmit read
   localparam ST_RXWR = 2'b10;  // DMA receive write
   reg  [8:0]  pin_meta;      // First synchroniser stage
   reg  [8:0]  pin_sync;      // Second synchroniser stage
   reg         txc_prev;      // Transmit clock history
   reg         rxc_prev;      // Receive clock history
   reg  [2:0]  div_cnt;       // DMA rate divider
   reg         dma_en;        // One-cycle DMA enable
   reg  [15:0] txf [0:DEPTH-1]; // Transmit FIFO storage
   reg  [15:0] rxf [0:DEPTH-1]; // Receive FIFO storage
   reg  [AW:0] txf_wp;        // Written by DMA
   reg  [AW:0] txf_rp;        // Read by transmit logic
   reg  [AW:0] rxf_wp;        // Written by receive logic
   reg  [AW:0] rxf_rp;        // Read by DMA
   reg  [15:0] tx_shift;      // Nibbles left in current word
   reg  [1:0]  tx_nib_left;   // Count of nibbles still to send
   reg  [15:0] rx_word;       // Receive nibble assembly
   reg  [1:0]  rx_nib_idx;    // Nibble position in word
   reg         rx_in_frame;   // Inside a valid envelope
   reg         rx_bad;        // Frame hit a code error or overrun
   reg  [15:0] rx_nibs;       // Nibbles in current frame
   reg         rx_end_tgl;    // Toggles at each frame end
   reg         rx_end_ack;    // DMA copy of the toggle
   reg         rx_end_bad;    // Error state of ended frame
   reg  [15:0] rx_end_nibs;   // Length of ended frame
   reg  [1:0]  state;         // DMA state
   reg         last_tx;       // Last grant was transmit
   reg  [15:0] tx_addr;       // Transmit memory address
   reg  [15:0] tx_left;       // Transmit 32-bit words left
   reg  [15:0] rx_off;        // Receive offset from base
   reg  [31:0] rx_hold;       // Two receive words
   reg  [1:0]  rx_half;       // Words held in rx_hold
   wire tx_rise = pin_sync[0] & ~txc_prev;
   wire rx_rise = pin_sync[1] & ~rxc_prev;
   wire [3:0] rx_nib_s = pin_sync[5:2];
   wire rx_dv_s = pin_sync[6];
   wire rx_err_s = pin_sync[7];
   wire [AW:0] txf_cnt = txf_wp - txf_rp;
   wire txf_empty = (txf_cnt == {(AW+1){1'b0}});
   wire [AW:0] rxf_cnt = rxf_wp - rxf_rp;
   wire rxf_empty = (rxf_cnt == {(AW+1){1'b0}});
   wire rxf_full = (rxf_cnt == DEPTH[AW:0]);
   wire [AW:0] tx_room = DEPTH[AW:0] - txf_cnt;
   wire rx_pend = rx_end_tgl ^ rx_end_ack;
   wire [15:0] rx_in_word = {rx_nib_s, rx_word[15:4]};
   // Room for two words from one 32-bit fetch
   wire tx_need = (tx_left != 16'h0000) && (tx_room >= 2);
   // RQ12 full pair or end flush
   wire rx_need = (rx_half == 2'h2) ||
                  (rx_half == 2'h1 && rx_pend && rxf_empty);
   reg  [15:0] rx_tail;       // Partial word, right aligned
   // Right-align a partial word at frame end
   always @* begin
      case (rx_nib_idx)
         2'h1: rx_tail = {12'h000, rx_word[15:12]};
         2'h2: rx_tail = {8'h00, rx_word[15:8]};
         2'h3: rx_tail = {4'h0, rx_word[15:4]};
         default: rx_tail = rx_word;
      endcase
   end
   // RQ18 two-stage pin synchronisers
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_meta <= 9'h000;
         pin_sync <= 9'h000;
         txc_prev <= 1'b0;
         rxc_prev <= 1'b0;
      end else begin
         pin_meta <= {mgmt_data_in, rx_err, rx_dv, rx_nibble,
                      rx_nibble_clock, tx_nibble_clock};
         pin_sync <= pin_meta;
         txc_prev <= pin_sync[0];
         rxc_prev <= pin_sync[1];
      end
   end
   // RQ10 divide to 50 MHz enable
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= `MFD_DIV_RST;
         dma_en <= 1'b0;
      end else if (div_cnt == `MFD_DMA_DIV - 1) begin
         div_cnt <= `MFD_DIV_RST;
         dma_en <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 3'h1;
         dma_en <= 1'b0;
      end
   end
   // Host decode and management pins
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phy_select_out_n <= 1'b1;
         mgmt_clock_out <= 1'b0;
         mgmt_data_out <= 1'b0;
         mgmt_data_seen <= 1'b0;
      end else begin
         // RQ5 RQ6 active-low PHY select
         phy_select_out_n <= ~(host_access &&
            host_addr <= `MFD_PHY_ADDR_TOP &&
            bank_sel == `MFD_PHY_BANK);
         // RQ15 management serial pins
         mgmt_clock_out <= mgmt_clock_set;
         mgmt_data_out <= mgmt_data_set;
         mgmt_data_seen <= pin_sync[8];
      end
   end
   // RQ8 transmit side, independent of receive
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_nibble <= 4'h0;
         fast_tx_envelope <= 1'b0;
         tx_shift <= 16'h0000;
         tx_nib_left <= 2'h0;
         txf_rp <= {(AW+1){1'b0}};
      end else if (tx_rise) begin
         if (tx_nib_left != 2'h0) begin
            // RQ1 next nibble out
            tx_nibble <= tx_shift[3:0];
            tx_shift <= {4'h0, tx_shift[15:4]};
            tx_nib_left <= tx_nib_left - 2'h1;
         end else if (!txf_empty) begin
            // RQ9 pop one 16-bit word
            tx_nibble <= txf[txf_rp[AW-1:0]][3:0];
            tx_shift <= {4'h0, txf[txf_rp[AW-1:0]][15:4]};
            tx_nib_left <= `MFD_LAST_NIB;
            txf_rp <= txf_rp + 1'b1;
         end else begin
            tx_nibble <= 4'h0;
         end
         // RQ17 envelope while nibbles flow
         fast_tx_envelope <= speed_fast &&
            (tx_nib_left != 2'h0 || !txf_empty);
      end
   end
   // RQ3 receive logic on receive clock edges
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_word <= 16'h0000;
         rx_nib_idx <= 2'h0;
         rx_in_frame <= 1'b0;
         rx_bad <= 1'b0;
         rx_nibs <= 16'h0000;
         rx_end_tgl <= 1'b0;
         rx_end_bad <= 1'b0;
         rx_end_nibs <= 16'h0000;
         rxf_wp <= {(AW+1){1'b0}};
      end else if (rx_rise) begin
         // RQ16 valid envelope frames data
         if (rx_dv_s) begin
            rx_in_frame <= 1'b1;
            rx_word <= rx_in_word;
            rx_nib_idx <= rx_nib_idx + 2'h1;
            rx_nibs <= rx_nibs + 16'h0001;
            // RQ4 code error or overrun discards
            if (rx_err_s || (rx_nib_idx == `MFD_LAST_NIB && rxf_full))
               rx_bad <= 1'b1;
            else if (rx_nib_idx == `MFD_LAST_NIB && !rx_bad) begin
               rxf[rxf_wp[AW-1:0]] <= rx_in_word;
               rxf_wp <= rxf_wp + 1'b1;
            end
         end else if (rx_in_frame) begin
            // Frame end: flush partial word, post status
            if (rx_nib_idx != 2'h0 && !rx_bad && !rxf_full) begin
               rxf[rxf_wp[AW-1:0]] <= rx_tail;
               rxf_wp <= rxf_wp + 1'b1;
            end
            rx_end_bad <= rx_bad;
            rx_end_nibs <= rx_nibs;
            rx_end_tgl <= ~rx_end_tgl;
            rx_in_frame <= 1'b0;
            rx_bad <= 1'b0;
            rx_nibs <= 16'h0000;
            rx_nib_idx <= 2'h0;
         end
      end
   end
   // DMA engine, one step per 50 MHz enable
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         last_tx <= 1'b0;
         tx_addr <= 16'h0000;
         tx_left <= 16'h0000;
         rx_off <= 16'h0000;
         rx_hold <= 32'h0000_0000;
         rx_half <= 2'h0;
         rx_end_ack <= 1'b0;
         txf_wp <= {(AW+1){1'b0}};
         rxf_rp <= {(AW+1){1'b0}};
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 32'h0000_0000;
         tx_busy <= 1'b0;
         rx_done <= 1'b0;
         rx_status <= 16'h0000;
         rx_byte_count <= 16'h0000;
      end else begin
         rx_done <= 1'b0;
         tx_busy <= (tx_left != 16'h0000) || !txf_empty ||
                    (tx_nib_left != 2'h0);
         // RQ13 transmit counters loaded on start
         if (tx_go && state != ST_TXRD) begin
            tx_addr <= tx_base;
            tx_left <= tx_dwords;
         end
         if (dma_en) begin
            // RQ12 gather receive words into the pair
            if (state != ST_RXWR && rx_half != 2'h2 && !rxf_empty) begin
               if (rx_half == 2'h0)
                  rx_hold[15:0] <= rxf[rxf_rp[AW-1:0]];
               else
                  rx_hold[31:16] <= rxf[rxf_rp[AW-1:0]];
               rx_half <= rx_half + 2'h1;
               rxf_rp <= rxf_rp + 1'b1;
            end else if (state == ST_IDLE && rx_pend && rxf_empty &&
                         rx_half == 2'h0) begin
               // RQ4 report frame and its bad CRC
               rx_done <= 1'b1;
               rx_status <= 16'h0000;
               rx_status[`MFD_BAD_CRC_BIT] <= rx_end_bad;
               rx_byte_count <= {1'b0, rx_end_nibs[15:1]};
               rx_end_ack <= rx_end_tgl;
               rx_off <= 16'h0000;
            end
            case (state)
               ST_IDLE: begin
                  // RQ14 alternate when both wait
                  if (tx_need && (!rx_need || !last_tx)) begin
                     state <= ST_TXRD;
                     mem_req <= 1'b1;
                     mem_we <= 1'b0;
                     mem_addr <= tx_addr;
                  end else if (rx_need) begin
                     state <= ST_RXWR;
                     mem_req <= 1'b1;
                     mem_we <= 1'b1;
                     mem_addr <= rx_base + rx_off;
                     mem_wdata <= (rx_half == 2'h2) ? rx_hold :
                                  {16'h0000, rx_hold[15:0]};
                  end
               end
               ST_TXRD: begin
                  // RQ11 fetched word into transmit FIFO
                  if (mem_ack) begin
                     txf[txf_wp[AW-1:0]] <= mem_rdata[15:0];
                     txf[txf_wp[AW-1:0] + 1'b1] <= mem_rdata[31:16];
                     txf_wp <= txf_wp + 2'h2;
                     tx_addr <= tx_addr + `MFD_ADDR_STEP;
                     tx_left <= tx_left - 16'h0001;
                     last_tx <= 1'b1;
                     mem_req <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
               ST_RXWR: begin
                  // RQ11 receive pair stored
                  if (mem_ack) begin
                     rx_off <= rx_off + `MFD_ADDR_STEP;
                     rx_half <= 2'h0;
                     last_tx <= 1'b0;
                     mem_req <= 1'b0;
                     mem_we <= 1'b0;
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
                  mem_req <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- tb/mfd_dp_properties.sv ----
/* Port checker for the packet data path.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ps
module mfd_dp_props (
   input logic        clock,
   input logic        rstn,
   input logic        host_access,
   input logic [3:0]  host_addr,
   input logic [2:0]  bank_sel,
   input logic        mgmt_clock_set,
   input logic        mgmt_data_set,
   input logic        mgmt_clock_out,
   input logic        mgmt_data_out,
   input logic        phy_select_out_n,
   input logic        mem_req,
   input logic        mem_ack,
   input logic [15:0] mem_addr,
   input logic        tx_busy,
   input logic        fast_tx_envelope,
   input logic        rx_done
);
   // Host cycle on the low eight addresses of bank 7
   wire hit = host_access && host_addr <= 4'h7 && bank_sel == 3'h7;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   AST_SEL_ON: assert property (hit |=> !phy_select_out_n)
      else $error("select missing");
   AST_SEL_OFF: assert property (!hit |=> phy_select_out_n)
      else $error("select stray");
   AST_MGMT: assert property (##1 mgmt_clock_out == $past(mgmt_clock_set)
      && mgmt_data_out == $past(mgmt_data_set)) else $error("mgmt pins");
   AST_HOLD: assert property (mem_req && !mem_ack |=> mem_req
      && $stable(mem_addr)) else $error("request moved");
   AST_GAP: assert property ($fell(mem_req) |-> !mem_req [*5])
      else $error("request too soon");
   AST_DROP: assert property (mem_req && mem_ack |-> ##[1:5] !mem_req)
      else $error("grant not taken");
   AST_ENV: assert property ($rose(fast_tx_envelope) |-> tx_busy)
      else $error("envelope while idle");
   AST_PULSE: assert property (rx_done |=> !rx_done)
      else $error("done too long");
   C_RX: cover property (rx_done);
   C_GRANT: cover property (mem_req && mem_ack);
   C_TX: cover property ($rose(fast_tx_envelope));
endmodule
bind mfd_datapath mfd_dp_props u_mfd_dp_props (
   .clock, .rstn, .host_access, .host_addr, .bank_sel, .mgmt_clock_set,
   .mgmt_data_set, .mgmt_clock_out, .mgmt_data_out, .phy_select_out_n,
   .mem_req, .mem_ack, .mem_addr, .tx_busy, .fast_tx_envelope, .rx_done
);

// ---- tb/mfd_phy_model.sv ----
/* PHY stand-in: free nibble clocks, frame source, nibble capture.
   Assumes 160 ns nibble periods off the system clock grid. */
`timescale 1ns/1ps
module mfd_phy_model (
   output logic       tx_nibble_clock,
   output logic       rx_nibble_clock,
   output logic [3:0] rx_nibble,
   output logic       rx_dv,
   output logic       rx_err,
   input  logic [3:0] tx_nibble,
   input  logic       fast_tx_envelope
);
   logic [3:0] tx_q[$];  // Nibbles caught inside the envelope
   // Idle lines sit at their pull levels
   initial begin
      tx_nibble_clock = 1'b0;
      rx_nibble_clock = 1'b0;
      rx_nibble = 4'hf;
      rx_dv = 1'b0;
      rx_err = 1'b0;
   end
   initial #1.3 forever #80 tx_nibble_clock = ~tx_nibble_clock;
   initial #2.9 forever #80 rx_nibble_clock = ~rx_nibble_clock;
   always @(posedge tx_nibble_clock)
      if (fast_tx_envelope)
         tx_q.push_back(tx_nibble);
   // receive envelope
   // Data moves on the falling edge, centred on the rising one
   task automatic send_frame(input logic [31:0] d, input int err_at);
      for (int i = 0; i < 8; i++) begin
         @(negedge rx_nibble_clock);
         rx_dv = 1'b1;
         rx_nibble = d[4*i +: 4];
         rx_err = (i == err_at);
      end
      @(negedge rx_nibble_clock);
      rx_dv = 1'b0;
      rx_err = 1'b0;
      rx_nibble = 4'hf;
   endtask
endmodule

// ---- tb/tb_top.sv ----
/* Bench for the packet data path with arbiter stand-in.
   Assumes a 250 MHz clock and the PHY model beside it. */
`timescale 1ns/1ps
module tb_top;
   logic        clock, rstn, rx_dv, rx_err, mgmt_data_in, mgmt_clock_set;
   logic        mgmt_data_set, host_access, speed_fast, tx_go, mem_ack;
   logic        tx_nibble_clock, rx_nibble_clock, fast_tx_envelope;
   logic        mgmt_clock_out, mgmt_data_out, mgmt_data_seen, tx_busy;
   logic        phy_select_out_n, rx_done, mem_req, mem_we, ack_pend;
   logic [3:0]  rx_nibble, host_addr, tx_nibble;
   logic [2:0]  bank_sel;
   logic [15:0] tx_base, tx_dwords, rx_base, rx_status, rx_byte_count;
   logic [15:0] mem_addr, rd_q[$], wa_q[$];
   logic [31:0] mem_rdata, mem_wdata, wd_q[$];
   int          n_errors, cmp_count, cycles, rx_seen;

   mfd_datapath u_mfd_datapath (
      .clock, .rstn, .tx_nibble_clock, .rx_nibble_clock, .rx_nibble,
      .rx_dv, .rx_err, .mgmt_data_in, .mgmt_clock_set, .mgmt_data_set,
      .host_access, .host_addr, .bank_sel, .speed_fast, .tx_go, .tx_base,
      .tx_dwords, .rx_base, .mem_ack, .mem_rdata, .tx_nibble,
      .fast_tx_envelope, .mgmt_clock_out, .mgmt_data_out, .mgmt_data_seen,
      .phy_select_out_n, .tx_busy, .rx_done, .rx_status, .rx_byte_count,
      .mem_req, .mem_we, .mem_addr, .mem_wdata
   );
   mfd_phy_model u_mfd_phy_model (
      .tx_nibble_clock, .rx_nibble_clock, .rx_nibble, .rx_dv, .rx_err,
      .tx_nibble, .fast_tx_envelope
   );

   always #2 clock = ~clock;

   // Arbiter stand-in: logs each request once, grants one cycle late
   always @(negedge clock) begin
      if (mem_req && !ack_pend && mem_we) begin
         wa_q.push_back(mem_addr);
         wd_q.push_back(mem_wdata);
      end
      if (mem_req && !ack_pend && !mem_we)
         rd_q.push_back(mem_addr);
      if (rx_done === 1'b1)
         rx_seen++;
      mem_ack <= mem_req && ack_pend;
      ack_pend <= mem_req;
      mem_rdata <= {mem_addr ^ 16'ha5a5, mem_addr};
   end

   // Watchdog on run length
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic compare(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Every address in two banks, then an idle bus
   // host cycles on system clock
   task automatic t_select();
      for (int b = 6; b < 8; b++) begin
         for (int a = 0; a < 16; a++) begin
            @(negedge clock);
            host_access = 1'b1;
            host_addr = a[3:0];
            bank_sel = b[2:0];
            @(negedge clock);
            compare("select", (a > 7 || b != 7), phy_select_out_n);
         end
      end
      host_access = 1'b0;
      host_addr = 4'h0;
      @(negedge clock);
      compare("select idle", 1'b1, phy_select_out_n);
   endtask

   // All level pairs on the management pins
   task automatic t_mgmt();
      for (int i = 0; i < 4; i++) begin
         @(negedge clock);
         mgmt_clock_set = i[0];
         mgmt_data_set = i[1];
         mgmt_data_in = i[1];
         @(negedge clock);
         compare("mgmt clock", i[0], mgmt_clock_out);
         compare("mgmt data", i[1], mgmt_data_out);
         repeat (3) @(negedge clock);
         compare("mgmt seen", i[1], mgmt_data_seen);
      end
   endtask

   // Fetch n doublewords and match the nibble stream to them
   task automatic run_tx(input logic [15:0] base, input int n);
      logic [31:0] d;
      logic [3:0]  q[$];
      int          k;
      rd_q.delete();
      u_mfd_phy_model.tx_q.delete();
      @(negedge clock);
      tx_base = base;
      tx_dwords = n[15:0];
      tx_go = 1'b1;
      @(negedge clock);
      tx_go = 1'b0;
      repeat (2) @(negedge clock);
      compare("tx_busy", 1'b1, tx_busy);
      for (k = 0; k < 3000 && (tx_busy || fast_tx_envelope); k++)
         @(negedge clock);
      q = u_mfd_phy_model.tx_q;
      compare("reads", n, rd_q.size());
      compare("tx nibbles", 8 * n, q.size());
      for (int i = 0; i < n; i++) begin
         d[15:0] = base + 16'(4 * i);
         d[31:16] = d[15:0] ^ 16'ha5a5;
         compare("read address", d[15:0], rd_q[i]);
         for (int j = 0; j < 8; j++)
            compare("tx nibble", d[4*j +: 4], q[8*i+j]);
      end
   endtask

   // Slow mode: words still fetched and sent, no fast envelope
   task automatic t_slow_tx();
      int k;
      speed_fast = 1'b0;
      rd_q.delete();
      u_mfd_phy_model.tx_q.delete();
      @(negedge clock);
      tx_base = 16'h0400;
      tx_dwords = 16'h0001;
      tx_go = 1'b1;
      @(negedge clock);
      tx_go = 1'b0;
      for (k = 0; k < 3000 && (k < 3 || tx_busy); k++)
         @(negedge clock);
      compare("slow reads", 1, rd_q.size());
      compare("slow address", 16'h0400, rd_q[0]);
      compare("slow nibbles", 0, u_mfd_phy_model.tx_q.size());
      compare("slow busy", 0, tx_busy);
      speed_fast = 1'b1;
   endtask

   // One eight-nibble frame, with a code error when err_at is set
   task automatic run_rx(input logic [31:0] d, input int err_at);
      int k;
      wa_q.delete();
      wd_q.delete();
      rx_seen = 0;
      u_mfd_phy_model.send_frame(d, err_at);
      for (k = 0; k < 1000 && rx_seen == 0; k++)
         @(negedge clock);
      compare("rx_done", 1, rx_seen);
      compare("rx_status", err_at < 0 ? 0 : 16'h2000, rx_status);
      if (err_at < 0) begin
         compare("rx_byte_count", 16'h0004, rx_byte_count);
         compare("writes", 1, wa_q.size());
         compare("write address", rx_base, wa_q[0]);
         compare("write data", d, wd_q[0]);
      end
   endtask

   initial begin
      {clock, rstn, mgmt_data_in, mgmt_clock_set, mgmt_data_set} = 5'h00;
      {host_access, tx_go, mem_ack, ack_pend} = 4'h0;
      {host_addr, bank_sel, tx_base, tx_dwords} = 39'h00_0000_0000;
      mem_rdata = 32'h0000_0000;
      rx_base = 16'h0200;
      speed_fast = 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      t_select();
      $display("test select done");
      t_mgmt();
      $display("test management done");
      run_tx(16'h0100, 2);
      $display("test transmit done");
      t_slow_tx();
      $display("test slow transmit done");
      run_rx(32'h1234_5678, 2);
      $display("test receive error done");
      run_rx(32'h8765_4321, -1);
      $display("test receive done");
      fork
         run_tx(16'h0300, 3);
         run_rx(32'hcafe_f00d, -1);
      join
      $display("test duplex done");
      conclude();
   end
endmodule
